// *** rtl/cam_pkg.sv ***
// What this block does
// - Inherent opcodes are one byte; no operand or address bytes follow.
// - Immediate is two bytes; second byte is the operand, no memory read.
// - Short direct takes one address byte, reaching 00 to FF.
// - Long direct takes a two-byte address, reaching all 64 Kbyte.
// - Indexed address is unsigned sum of chosen index register and offset.
// - Indexed without offset uses the index register alone, 00 to FF.
// - Short indexed adds one offset byte without wrap, 00 to 1FE.
// - Long indexed adds a two-byte offset word, whole 64 Kbyte space.
// - Indirect takes pointer address byte, fetches pointer, uses it as address.
// - Indirect takes one pointer-address byte; byte pointer or word pointer.
// - Indirect indexed adds index register to fetched pointer, unsigned.
// - Short direct stays in page zero, short indexed reaches 1FE; long modes reach 64 Kbyte.
// - Read-modify-write memory instructions only use short sub-modes.
// - Set-mask raises interrupt mask to 3; clear-mask lowers it to 0.
// - Halt stops the oscillator; wait-for-irq waits until an interrupt.
// - Relative mode adds a signed 8-bit offset, direct or fetched.
// - Prefix 90 swaps the first index register for the alternate one.
// - Prefix 92 turns short direct into indirect, short indexed into indirect indexed.
// - Prefix 91 makes first-register indirect indexed use the alternate.
package cam_pkg;
	localparam logic [7:0]  PFX_ALT      = 8'h90;
	localparam logic [7:0]  PFX_IND      = 8'h92;
	localparam logic [7:0]  PFX_IND_ALT  = 8'h91;
	localparam logic [7:0]  OP_SET_MASK  = 8'h9B;
	localparam logic [7:0]  OP_CLR_MASK  = 8'h9A;
	localparam logic [7:0]  OP_HALT      = 8'h8E;
	localparam logic [7:0]  OP_WAIT      = 8'h8F;
	localparam logic [1:0]  MASK_HIGH    = 2'h3;
	localparam logic [1:0]  MASK_LOW     = 2'h0;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [15:0] ONE16        = 16'h0001;

	// Opcode high nibble groups, plus the word-pointer low nibble
	localparam logic [3:0]  HN_BITOP     = 4'h1;
	localparam logic [3:0]  HN_BTJ       = 4'h0;
	localparam logic [3:0]  HN_REL       = 4'h2;
	localparam logic [3:0]  HN_RMW_DIR   = 4'h3;
	localparam logic [3:0]  HN_RMW_IX1   = 4'h6;
	localparam logic [3:0]  HN_RMW_IX0   = 4'h7;
	localparam logic [3:0]  HN_IMM       = 4'hA;
	localparam logic [3:0]  HN_DIR       = 4'hB;
	localparam logic [3:0]  HN_EXT       = 4'hC;
	localparam logic [3:0]  HN_IX2       = 4'hD;
	localparam logic [3:0]  HN_IX1       = 4'hE;
	localparam logic [3:0]  HN_IX0       = 4'hF;
	localparam logic [3:0]  LN_LONG_PTR  = 4'hC;

	// Addressing mode, one-hot
	typedef enum logic [10:0] {
		AM_INH  = 11'h001,
		AM_IMM  = 11'h002,
		AM_DIR  = 11'h004,
		AM_EXT  = 11'h008,
		AM_IX0  = 11'h010,
		AM_IX1  = 11'h020,
		AM_IX2  = 11'h040,
		AM_IND  = 11'h080,
		AM_INDX = 11'h100,
		AM_REL  = 11'h200,
		AM_BIT  = 11'h400
	} cam_mode_t;

	// Decoded opcode
	typedef struct packed {
		cam_mode_t  mode;
		logic [1:0] n_bytes;   // Bytes after opcode, before pointer use
		logic       long_ptr;  // Word pointer in indirect modes
		logic       branch;    // Bit test carries displacement
		logic       rmw;       // Read-modify-write on memory
	} cam_dec_t;

	// Memory request
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} cam_mem_t;
endpackage

// *** rtl/cam_decode.sv ***
`timescale 1ns/1ns
// Opcode to addressing-mode table, combinational
module cam_decode (
	input  wire logic [7:0]      op_in,
	input  wire logic            pfx_ind_in,
	output cam_pkg::cam_dec_t    dec_out
);
	logic [3:0] hn;
	logic [3:0] ln;
	assign hn = op_in[7:4];
	assign ln = op_in[3:0];

	// Mode and length from the high nibble
	always_comb begin
		dec_out          = '0;
		dec_out.mode     = cam_pkg::AM_INH;
		dec_out.long_ptr = (ln == cam_pkg::LN_LONG_PTR);
		unique case (hn)
			cam_pkg::HN_IMM: begin
				dec_out.mode    = cam_pkg::AM_IMM;
				dec_out.n_bytes = 2'd1;
			end
			cam_pkg::HN_DIR: begin
				dec_out.mode    = pfx_ind_in ? cam_pkg::AM_IND : cam_pkg::AM_DIR;
				dec_out.n_bytes = 2'd1;
			end
			cam_pkg::HN_EXT: begin
				dec_out.mode    = cam_pkg::AM_EXT;
				dec_out.n_bytes = 2'd2;
			end
			cam_pkg::HN_IX0: dec_out.mode = cam_pkg::AM_IX0;
			cam_pkg::HN_IX1: begin
				dec_out.mode    = pfx_ind_in ? cam_pkg::AM_INDX : cam_pkg::AM_IX1;
				dec_out.n_bytes = 2'd1;
			end
			cam_pkg::HN_IX2: begin
				dec_out.mode    = cam_pkg::AM_IX2;
				dec_out.n_bytes = 2'd2;
			end
			// Memory RMW: short sub-modes only, no long form exists
			cam_pkg::HN_RMW_DIR: begin
				dec_out.mode     = pfx_ind_in ? cam_pkg::AM_IND : cam_pkg::AM_DIR;
				dec_out.n_bytes  = 2'd1;
				dec_out.rmw      = 1'b1;
				dec_out.long_ptr = 1'b0;
			end
			cam_pkg::HN_RMW_IX1: begin
				dec_out.mode     = pfx_ind_in ? cam_pkg::AM_INDX : cam_pkg::AM_IX1;
				dec_out.n_bytes  = 2'd1;
				dec_out.rmw      = 1'b1;
				dec_out.long_ptr = 1'b0;
			end
			cam_pkg::HN_RMW_IX0: begin
				dec_out.mode = cam_pkg::AM_IX0;
				dec_out.rmw  = 1'b1;
			end
			cam_pkg::HN_REL: begin
				dec_out.mode     = cam_pkg::AM_REL;
				dec_out.n_bytes  = 2'd1;
				dec_out.long_ptr = 1'b0;
			end
			cam_pkg::HN_BITOP, cam_pkg::HN_BTJ: begin
				dec_out.mode     = cam_pkg::AM_BIT;
				dec_out.n_bytes  = 2'd1;
				dec_out.branch   = (hn == cam_pkg::HN_BTJ);
				dec_out.long_ptr = 1'b0;
			end
			default: dec_out.mode = cam_pkg::AM_INH;
		endcase
	end
endmodule // cam_decode

// *** rtl/cam_addgen.sv ***
`timescale 1ns/1ns
// Unsigned index plus base adder; no wrap inside 16 bits for short forms
module cam_addgen (
	input  wire logic [7:0]  index_in,
	input  wire logic [15:0] base_in,
	input  wire logic        use_index_in,
	output logic      [15:0] addr_out
);
	// Byte base plus byte index peaks at 1FE; a word base plus index can wrap past FFFF
	assign addr_out = use_index_in ? base_in + {cam_pkg::BYTE_ZERO, index_in} : base_in;
endmodule // cam_addgen

// *** rtl/cam_core.sv ***
`timescale 1ns/1ns
// Operand address sequencer: fetches instruction bytes, forms effective address
module cam_core (
	input  wire logic              CLK_IN,
	input  wire logic              NRST_IN,
	input  wire logic              START_IN,
	input  wire logic              MEM_ACK_IN,
	input  wire logic [7:0]        MEM_RDATA_IN,
	input  wire logic [7:0]        FIRST_PTR_IN,
	input  wire logic [7:0]        ALT_PTR_IN,
	input  wire logic              IRQ_IN,
	output cam_pkg::cam_mem_t      FETCH_OUT,
	output logic      [15:0]       EA_OUT,
	output logic      [7:0]        OPERAND_OUT,
	output logic                   EA_VALID_OUT,
	output logic                   IMM_VALID_OUT,
	output logic                   RMW_OUT,
	output logic      [2:0]        BIT_NUM_OUT,
	output logic      [7:0]        BRANCH_DISP_OUT,
	output logic      [15:0]       PROGRAM_COUNTER_OUT,
	output logic      [1:0]        IRQ_MASK_OUT,
	output logic                   HALT_OUT,
	output logic                   WAIT_OUT,
	output logic                   DONE_OUT
);
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_OP    = 9'h002,
		ST_ARG1  = 9'h004,
		ST_ARG2  = 9'h008,
		ST_PTRH  = 9'h010,
		ST_PTRL  = 9'h020,
		ST_DISP  = 9'h040,
		ST_ADDR  = 9'h080,
		ST_SLEEP = 9'h100
	} cam_state_t;

	cam_state_t          state_ff;
	cam_pkg::cam_dec_t   dec;
	cam_pkg::cam_dec_t   dec_ff;
	logic [7:0]          op_ff;
	logic                pfx_alt_ff;
	logic                pfx_ind_ff;
	logic                pfx_ind_alt_ff;
	logic [15:0]         pc_ff;
	logic [15:0]         arg_ff;
	logic [15:0]         ptr_ff;
	logic [15:0]         ea_ff;
	logic [15:0]         ea_raw;
	logic [15:0]         base;
	logic [7:0]          index;
	logic                use_index;
	logic [7:0]          operand_ff;
	logic                ea_valid_ff;
	logic                imm_valid_ff;
	logic                done_ff;
	logic [7:0]          disp_ff;
	logic [1:0]          mask_ff;
	logic                halt_ff;
	logic                wait_ff;
	logic                byte_taken;
	logic                via_ptr;

	assign byte_taken = MEM_ACK_IN;

	cam_decode u_decode (
		.op_in      (MEM_RDATA_IN),
		.pfx_ind_in (pfx_ind_ff),
		.dec_out    (dec)
	);

	// Index select, and whether a pointer is fetched before the address is formed
	assign index = (pfx_alt_ff || pfx_ind_alt_ff) ? ALT_PTR_IN : FIRST_PTR_IN;
	assign via_ptr = (dec_ff.mode inside {cam_pkg::AM_IND, cam_pkg::AM_INDX}) ||
	                 (pfx_ind_ff && (dec_ff.mode inside {cam_pkg::AM_REL, cam_pkg::AM_BIT}));

	// Base per mode before the index is added
	always_comb begin
		base      = arg_ff;
		use_index = 1'b0;
		unique case (dec_ff.mode)
			cam_pkg::AM_IX0: begin
				base      = '0;
				use_index = 1'b1;
			end
			cam_pkg::AM_IX1: begin
				base      = {cam_pkg::BYTE_ZERO, arg_ff[7:0]};
				use_index = 1'b1;
			end
			cam_pkg::AM_IX2: begin
				base      = arg_ff;
				use_index = 1'b1;
			end
			cam_pkg::AM_IND: base = ptr_ff;
			cam_pkg::AM_INDX: begin
				base      = ptr_ff;
				use_index = 1'b1;
			end
			cam_pkg::AM_DIR: base = {cam_pkg::BYTE_ZERO, arg_ff[7:0]};
			cam_pkg::AM_BIT: base = via_ptr ? ptr_ff : {cam_pkg::BYTE_ZERO, arg_ff[7:0]};
			cam_pkg::AM_REL: base = via_ptr ? ptr_ff : arg_ff;
			default: base = arg_ff;
		endcase
	end

	cam_addgen u_addgen (
		.index_in     (index),
		.base_in      (base),
		.use_index_in (use_index),
		.addr_out     (ea_raw)
	);

	// Fetch address: program bytes, or pointer bytes from page zero
	always_comb begin
		FETCH_OUT.req  = 1'b0;
		FETCH_OUT.addr = pc_ff;
		unique case (state_ff)
			ST_OP, ST_ARG1, ST_ARG2, ST_DISP: FETCH_OUT.req = 1'b1;
			ST_PTRH: begin
				FETCH_OUT.req  = 1'b1;
				FETCH_OUT.addr = {cam_pkg::BYTE_ZERO, arg_ff[7:0]};
			end
			ST_PTRL: begin
				FETCH_OUT.req  = 1'b1;
				FETCH_OUT.addr = {cam_pkg::BYTE_ZERO, arg_ff[7:0]} + cam_pkg::ONE16;
			end
			default: FETCH_OUT.req = 1'b0;
		endcase
	end

	// Instruction sequencer
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_ff <= ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE: if (START_IN) state_ff <= ST_OP;
				ST_OP: if (byte_taken) begin
					if (MEM_RDATA_IN == cam_pkg::PFX_ALT || MEM_RDATA_IN == cam_pkg::PFX_IND ||
					    MEM_RDATA_IN == cam_pkg::PFX_IND_ALT) begin
						state_ff <= ST_OP;
					end else if (MEM_RDATA_IN == cam_pkg::OP_HALT ||
					             MEM_RDATA_IN == cam_pkg::OP_WAIT) begin
						state_ff <= ST_SLEEP;
					end else if (dec.n_bytes == 2'd0) begin
						state_ff <= ST_ADDR;
					end else begin
						state_ff <= ST_ARG1;
					end
				end
				ST_ARG1: if (byte_taken) begin
					if (dec_ff.n_bytes == 2'd2) begin
						state_ff <= ST_ARG2;
					end else if (via_ptr) begin
						state_ff <= ST_PTRH;
					end else if (dec_ff.branch) begin
						state_ff <= ST_DISP;
					end else begin
						state_ff <= ST_ADDR;
					end
				end
				ST_ARG2: if (byte_taken) state_ff <= ST_ADDR;
				ST_PTRH: if (byte_taken) begin
					if (dec_ff.long_ptr) begin
						state_ff <= ST_PTRL;
					end else if (dec_ff.branch) begin
						state_ff <= ST_DISP;
					end else begin
						state_ff <= ST_ADDR;
					end
				end
				ST_PTRL: if (byte_taken) state_ff <= ST_ADDR;
				ST_DISP: if (byte_taken) state_ff <= ST_ADDR;
				ST_ADDR: state_ff <= ST_IDLE;
				ST_SLEEP: if (IRQ_IN && wait_ff) state_ff <= ST_IDLE;
			endcase
		end
	end

	// Opcode, prefix and decode capture
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			op_ff          <= '0;
			dec_ff         <= '0;
			pfx_alt_ff     <= 1'b0;
			pfx_ind_ff     <= 1'b0;
			pfx_ind_alt_ff <= 1'b0;
		end else if (state_ff == ST_IDLE && START_IN) begin
			pfx_alt_ff     <= 1'b0;
			pfx_ind_ff     <= 1'b0;
			pfx_ind_alt_ff <= 1'b0;
		end else if (state_ff == ST_OP && byte_taken) begin
			if (MEM_RDATA_IN == cam_pkg::PFX_ALT) begin
				pfx_alt_ff <= 1'b1;
			end else if (MEM_RDATA_IN == cam_pkg::PFX_IND) begin
				pfx_ind_ff <= 1'b1;
			end else if (MEM_RDATA_IN == cam_pkg::PFX_IND_ALT) begin
				pfx_ind_ff     <= 1'b1;
				pfx_ind_alt_ff <= 1'b1;
			end else begin
				op_ff  <= MEM_RDATA_IN;
				dec_ff <= dec;
			end
		end
	end

	// Program counter advances once per fetched program byte
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pc_ff <= cam_pkg::PC_RESET;
		end else if (byte_taken && state_ff != ST_PTRH && state_ff != ST_PTRL &&
		             FETCH_OUT.req) begin
			pc_ff <= pc_ff + cam_pkg::ONE16;
		end else if (state_ff == ST_ADDR && dec_ff.mode == cam_pkg::AM_REL) begin
			pc_ff <= pc_ff + {{8{ea_raw[7]}}, ea_raw[7:0]};
		end
	end

	// Argument and pointer bytes, high byte first
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			arg_ff <= '0;
			ptr_ff <= '0;
			disp_ff <= '0;
		end else if (byte_taken) begin
			unique case (state_ff)
				ST_OP:   arg_ff <= '0;
				ST_ARG1: arg_ff <= {arg_ff[7:0], MEM_RDATA_IN};
				ST_ARG2: arg_ff <= {arg_ff[7:0], MEM_RDATA_IN};
				ST_PTRH: ptr_ff <= dec_ff.long_ptr ? {MEM_RDATA_IN, cam_pkg::BYTE_ZERO}
				                                   : {cam_pkg::BYTE_ZERO, MEM_RDATA_IN};
				ST_PTRL: ptr_ff <= {ptr_ff[15:8], MEM_RDATA_IN};
				ST_DISP: disp_ff <= MEM_RDATA_IN;
				default: arg_ff <= arg_ff;
			endcase
		end
	end

	// Results: address or immediate only after all bytes are in
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ea_ff        <= '0;
			operand_ff   <= '0;
			ea_valid_ff  <= 1'b0;
			imm_valid_ff <= 1'b0;
			done_ff      <= 1'b0;
		end else begin
			ea_valid_ff  <= 1'b0;
			imm_valid_ff <= 1'b0;
			done_ff      <= (state_ff == ST_ADDR);
			if (state_ff == ST_ADDR) begin
				ea_ff        <= ea_raw;
				operand_ff   <= arg_ff[7:0];
				imm_valid_ff <= (dec_ff.mode == cam_pkg::AM_IMM);
				ea_valid_ff  <= !(dec_ff.mode inside {cam_pkg::AM_IMM, cam_pkg::AM_INH,
				                                      cam_pkg::AM_REL});
			end
		end
	end

	// Interrupt mask and power state from inherent ops
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			mask_ff <= cam_pkg::MASK_HIGH;
			halt_ff <= 1'b0;
			wait_ff <= 1'b0;
		end else if (state_ff == ST_OP && byte_taken) begin
			if (MEM_RDATA_IN == cam_pkg::OP_SET_MASK) mask_ff <= cam_pkg::MASK_HIGH;
			if (MEM_RDATA_IN == cam_pkg::OP_CLR_MASK) mask_ff <= cam_pkg::MASK_LOW;
			halt_ff <= (MEM_RDATA_IN == cam_pkg::OP_HALT);
			wait_ff <= (MEM_RDATA_IN == cam_pkg::OP_WAIT);
		end else if (state_ff == ST_SLEEP && IRQ_IN && wait_ff) begin
			wait_ff <= 1'b0; // Halt leaves only by reset here
		end
	end

	assign EA_OUT              = ea_ff;
	assign OPERAND_OUT         = operand_ff;
	assign EA_VALID_OUT        = ea_valid_ff;
	assign IMM_VALID_OUT       = imm_valid_ff;
	assign DONE_OUT            = done_ff;
	assign RMW_OUT             = dec_ff.rmw;
	assign BIT_NUM_OUT         = op_ff[3:1];
	assign BRANCH_DISP_OUT     = disp_ff;
	assign PROGRAM_COUNTER_OUT = pc_ff;
	assign IRQ_MASK_OUT        = mask_ff;
	assign HALT_OUT            = halt_ff;
	assign WAIT_OUT            = wait_ff;

	property p_imm_no_ea;
		@(posedge CLK_IN) disable iff (!NRST_IN) IMM_VALID_OUT |-> !EA_VALID_OUT;
	endproperty
	a_imm_no_ea: assert property (p_imm_no_ea) else $error("immediate gave address");
	property p_short_page0;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_ADDR && dec_ff.mode == cam_pkg::AM_DIR) |=> EA_OUT[15:8] == 8'h00;
	endproperty
	a_short_page0: assert property (p_short_page0) else $error("short direct left page 0");
	property p_ix1_range;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_ADDR && dec_ff.mode == cam_pkg::AM_IX1) |=> EA_OUT <= 16'h01FE;
	endproperty
	a_ix1_range: assert property (p_ix1_range) else $error("short indexed over 1FE");
	property p_ix0_addr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_ADDR && dec_ff.mode == cam_pkg::AM_IX0) |=> EA_OUT == {8'h00, $past(index)};
	endproperty
	a_ix0_addr: assert property (p_ix0_addr) else $error("no-offset index wrong");
	property p_ind_ptr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_ADDR && dec_ff.mode == cam_pkg::AM_IND) |=> EA_OUT == $past(ptr_ff);
	endproperty
	a_ind_ptr: assert property (p_ind_ptr) else $error("indirect address not pointer");
	property p_set_mask;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_OP && byte_taken && MEM_RDATA_IN == cam_pkg::OP_SET_MASK)
			|=> IRQ_MASK_OUT == 2'h3;
	endproperty
	a_set_mask: assert property (p_set_mask) else $error("mask not raised");
	property p_clr_mask;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_OP && byte_taken && MEM_RDATA_IN == cam_pkg::OP_CLR_MASK)
			|=> IRQ_MASK_OUT == 2'h0;
	endproperty
	a_clr_mask: assert property (p_clr_mask) else $error("mask not cleared");
	sequence s_inh_op;
		state_ff == ST_OP && byte_taken && dec.n_bytes == 2'd0 &&
		!(MEM_RDATA_IN inside {8'h90, 8'h91, 8'h92, 8'h8E, 8'h8F});
	endsequence
	property p_inh_one_byte;
		@(posedge CLK_IN) disable iff (!NRST_IN) s_inh_op |=> state_ff == ST_ADDR ##1 DONE_OUT;
	endproperty
	a_inh_one_byte: assert property (p_inh_one_byte) else $error("inherent fetched more");
	property p_halt;
		@(posedge CLK_IN) disable iff (!NRST_IN)
			(state_ff == ST_OP && byte_taken && MEM_RDATA_IN == cam_pkg::OP_HALT)
			|=> HALT_OUT && state_ff == ST_SLEEP;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not entered");
endmodule // cam_core

// *** dv/cam_mem_model.sv ***
`timescale 1ns/1ns
// Byte-wide program and data memory answering the core's fetches
module cam_mem_model (
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	input  wire cam_pkg::cam_mem_t  fetch_in,
	input  wire logic               slow_in,
	output logic                    ack_out,
	output logic      [7:0]         rdata_out
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_ff;
	logic [7:0] last_ff;

	// Slow mode keeps every request waiting two cycles before the answer
	assign ack_out = fetch_in.req && (wait_ff >= (slow_in ? 2'h2 : 2'h0));
	// Idle bus shows the inverse of the last byte, so stale data never passes
	assign rdata_out = ack_out ? mem[fetch_in.addr] : ~last_ff;

	// Wait count and last byte handed out
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_ff <= 2'h0;
			last_ff <= 8'h00;
		end else if (ack_out) begin
			wait_ff <= 2'h0;
			last_ff <= rdata_out;
		end else if (fetch_in.req && wait_ff != 2'h3) begin
			wait_ff <= wait_ff + 2'h1;
		end
	end
endmodule // cam_mem_model

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic              clk, nrst, start, irq, slow, ack, ea_valid, imm_valid, rmw;
	logic              done, halt, wt, ea_v, imm_v;
	logic        [7:0] first, alt, rdata, operand, disp;
	logic        [2:0] bitn;
	logic        [1:0] mask;
	logic       [15:0] ea, pc, exp_pc;
	cam_pkg::cam_mem_t fetch;
	int                fail_count = 0;
	int                samples_checked = 0;

	cam_core i_cam_core (.CLK_IN(clk), .NRST_IN(nrst), .START_IN(start), .MEM_ACK_IN(ack),
		.MEM_RDATA_IN(rdata), .FIRST_PTR_IN(first), .ALT_PTR_IN(alt), .IRQ_IN(irq),
		.FETCH_OUT(fetch), .EA_OUT(ea), .OPERAND_OUT(operand), .EA_VALID_OUT(ea_valid),
		.IMM_VALID_OUT(imm_valid), .RMW_OUT(rmw), .BIT_NUM_OUT(bitn),
		.BRANCH_DISP_OUT(disp), .PROGRAM_COUNTER_OUT(pc), .IRQ_MASK_OUT(mask),
		.HALT_OUT(halt), .WAIT_OUT(wt), .DONE_OUT(done));
	cam_mem_model i_cam_mem_model (.clk_in(clk), .nrst_in(nrst), .fetch_in(fetch),
		.slow_in(slow), .ack_out(ack), .rdata_out(rdata));

	// Free-running core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop();
		if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		exp_pc = 16'h0000;
	endtask

	// Place one instruction at the expected pc, start it, count fetches
	task automatic exec(input logic [7:0] b [$], input int nf, input int adj);
		int acks;
		int i;
		acks = 0;
		for (i = 0; i < b.size(); i++) i_cam_mem_model.mem[exp_pc + 16'(i)] = b[i];
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		// Sample mid-cycle so the core's outputs have settled after the edge
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			if (fetch.req && ack) acks++;
			if (done || halt || wt) break;
		end
		ea_v = ea_valid;
		imm_v = imm_valid;
		exp_pc = exp_pc + 16'(b.size()) + 16'(adj);
		if (nf >= 0) begin
			`CHK("fetches", nf, acks)
			`CHK("pc", exp_pc, pc)
		end
	endtask

	task automatic t_inherent();
		exec({cam_pkg::OP_CLR_MASK}, 1, 0);
		`CHK("mask low", cam_pkg::MASK_LOW, mask)
		`CHK("inh ea", 1'b0, ea_v)
		exec({cam_pkg::OP_SET_MASK}, 1, 0);
		`CHK("mask high", cam_pkg::MASK_HIGH, mask)
	endtask

	task automatic t_immediate();
		exec({8'hA6, 8'h5A}, 2, 0);
		`CHK("imm data", 8'h5A, operand)
		`CHK("imm valid", 1'b1, imm_v)
		`CHK("imm ea", 1'b0, ea_v)
	endtask

	task automatic t_direct();
		exec({8'hB5, 8'h80}, 2, 0);
		`CHK("short dir", 16'h0080, ea)
		`CHK("dir rmw", 1'b0, rmw)
		exec({8'hC5, 8'hF2, 8'h34}, 3, 0);
		`CHK("long dir", 16'hF234, ea)
		`CHK("long valid", 1'b1, ea_v)
	endtask

	task automatic t_indexed();
		@(posedge clk);
		first <= 8'hAB;
		alt <= 8'h3C;
		exec({8'hF5}, 1, 0);
		`CHK("ix0", 16'h00AB, ea)
		exec({cam_pkg::PFX_ALT, 8'hF5}, 2, 0);
		`CHK("ix0 alt", 16'h003C, ea)
		@(posedge clk);
		first <= 8'hFF;
		exec({8'hE5, 8'hFF}, 2, 0);
		`CHK("ix1 top", 16'h01FE, ea)
		exec({8'hD5, 8'h12, 8'h00}, 3, 0);
		`CHK("ix2", 16'h12FF, ea)
	endtask

	task automatic t_indirect();
		i_cam_mem_model.mem[16'h00C0] = 8'h77;
		i_cam_mem_model.mem[16'h00C1] = 8'hAB;
		i_cam_mem_model.mem[16'h00C2] = 8'hCD;
		exec({cam_pkg::PFX_IND, 8'hB5, 8'hC0}, 4, 0);
		`CHK("ind byte", 16'h0077, ea)
		exec({cam_pkg::PFX_IND, 8'hBC, 8'hC1}, 5, 0);
		`CHK("ind word", 16'hABCD, ea)
	endtask

	task automatic t_ind_indexed();
		@(posedge clk);
		slow <= 1'b1;
		first <= 8'hFF;
		alt <= 8'h10;
		i_cam_mem_model.mem[16'h00D0] = 8'hF0;
		i_cam_mem_model.mem[16'h00D1] = 8'h20;
		i_cam_mem_model.mem[16'h00D2] = 8'h00;
		exec({cam_pkg::PFX_IND, 8'hE5, 8'hD0}, 4, 0);
		`CHK("indx first", 16'h01EF, ea)
		exec({cam_pkg::PFX_IND_ALT, 8'hE5, 8'hD0}, 4, 0);
		`CHK("indx alt", 16'h0100, ea)
		exec({cam_pkg::PFX_IND, 8'hEC, 8'hD1}, 5, 0);
		`CHK("indx word", 16'h20FF, ea)
		slow <= 1'b0;
	endtask

	// Relative jumps move the expected pc by the signed offset
	task automatic t_relative();
		i_cam_mem_model.mem[16'h00E0] = 8'h03;
		exec({8'h20, 8'h04}, 2, 4);
		exec({8'h20, 8'hFC}, 2, -4);
		exec({cam_pkg::PFX_IND, 8'h20, 8'hE0}, 4, 3);
	endtask

	task automatic t_rmw();
		@(posedge clk);
		first <= 8'h05;
		exec({8'h3C, 8'h10}, 2, 0);
		`CHK("rmw dir", 16'h0010, ea)
		`CHK("rmw flag", 1'b1, rmw)
		exec({8'h6C, 8'h20}, 2, 0);
		`CHK("rmw ix1", 16'h0025, ea)
		exec({8'h7C}, 1, 0);
		`CHK("rmw ix0", 16'h0005, ea)
	endtask

	task automatic t_bit();
		i_cam_mem_model.mem[16'h00E4] = 8'h33;
		exec({8'h17, 8'h10}, 2, 0);
		`CHK("bit num", 3'h3, bitn)
		`CHK("bit ea", 16'h0010, ea)
		exec({8'h01, 8'h20, 8'h05}, 3, 0);
		`CHK("btj disp", 8'h05, disp)
		`CHK("btj ea", 16'h0020, ea)
		exec({cam_pkg::PFX_IND, 8'h11, 8'hE4}, 4, 0);
		`CHK("bit ind", 16'h0033, ea)
	endtask

	// Wait leaves on an interrupt, halt only through reset
	task automatic t_power();
		int i;
		exec({cam_pkg::OP_WAIT}, -1, 0);
		`CHK("wait on", 1'b1, wt)
		@(posedge clk);
		irq <= 1'b1;
		for (i = 0; i < 10 && wt; i++) @(negedge clk);
		`CHK("wait off", 1'b0, wt)
		@(posedge clk);
		irq <= 1'b0;
		// Lower the mask first so the reset value below is really seen
		exec({cam_pkg::OP_CLR_MASK}, 1, 0);
		exec({cam_pkg::OP_HALT}, -1, 0);
		`CHK("halt on", 1'b1, halt)
		do_reset();
		@(negedge clk);
		`CHK("halt off", 1'b0, halt)
		`CHK("mask rst", cam_pkg::MASK_HIGH, mask)
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		start = 1'b0;
		irq = 1'b0;
		slow = 1'b0;
		first = 8'h00;
		alt = 8'h00;
		do_reset();
		t_inherent();
		t_immediate();
		t_direct();
		t_indexed();
		t_indirect();
		t_ind_indexed();
		t_relative();
		t_rmw();
		t_bit();
		t_power();
		report_and_stop();
	end

	// Hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule // testbench
